// ### hdl/lpt_config.v
// configuration register and trigger/clock front end of low-power timer
// Function
// - waveform bit 20 selects set-once output
// - retrigger off: running trigger ignored
// - retrigger on: running trigger restarts counter
// - trigger enable field picks start edges
// - four-bit selector picks nine trigger sources
// - prescaler divides by two to field
// - trigger filter needs 2/4/8 stable samples
// - clock filter needs 2/4/8 stable samples
// - filters sample on internal clock
// - polarity field picks external counting edge
// - both-edge counting needs fourfold sampling clock
// - encoder mode reuses polarity as submode
// - clock selector picks internal or external
// - continuous start arms, trigger starts counting
`timescale 1ns/1ps
`include "lpt_consts.vh"
module lpt_config (
	input wire core_clk,
	input wire rst_n,
	input wire cfg_wr,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	input wire timer_enable_bit,
	input wire continuous_start_cmd,
	input wire single_start_cmd,
	input wire timer_running,
	input wire [8:0] trig_sources,
	input wire ext_clock_in,
	output wire set_once_mode,
	output wire pwm_mode,
	output reg start_pulse,
	output reg restart_pulse,
	output reg armed_q,
	output reg count_tick,
	output reg [1:0] quad_submode,
	output wire ext_clock_selected,
	output reg trig_valid
);
	reg [31:0] cfg_q;
	reg trg_q;
	reg ext_q;
	reg [6:0] pre_q;
	reg trig_raw;
	reg raw_tick;
	reg pre_hit;
	wire trg_f;
	wire ext_f;
	wire [1:0] ten = cfg_q[`LPT_TEN_HI:`LPT_TEN_LO];
	wire [3:0] tsel = cfg_q[`LPT_TSEL_HI:`LPT_TSEL_LO];
	wire [2:0] pre = cfg_q[`LPT_PRE_HI:`LPT_PRE_LO];
	wire [1:0] pol = cfg_q[`LPT_POL_HI:`LPT_POL_LO];

	// edge match against a two-bit edge code (rise, fall, both)
	function edge_hit;
		input [1:0] code;
		input now;
		input prev;
		begin
			case (code)
			2'h0: edge_hit = now & ~prev;
			2'h1: edge_hit = ~now & prev;
			2'h2: edge_hit = now ^ prev;
			default: edge_hit = 1'b0;
			endcase
		end
	endfunction

	// terminal prescaler count for a divide by 2^code; the seven-bit
	// wrap turns code 7 into 7'h7f, the last count before 128
	function [6:0] pre_top;
		input [2:0] code;
		begin
			pre_top = (7'h01 << code) - 7'h01;
		end
	endfunction

	// register write only while disabled; reserved bits masked
	// dropping writes while enabled keeps a live count from ever seeing
	// a half-changed mix of old and new fields
	always @(posedge core_clk) begin
		if (!rst_n)
			cfg_q <= `LPT_CFG_RESET;
		else if (cfg_wr && !timer_enable_bit)
			cfg_q <= cfg_wdata & `LPT_CFG_WMASK;
	end

	// read data from flops, one cycle behind the register itself; the
	// mask is applied again so a reserved bit can never read as one
	always @(posedge core_clk) begin
		if (!rst_n)
			cfg_rdata <= 32'h0000_0000;
		else
			cfg_rdata <= cfg_q & `LPT_CFG_WMASK;
	end

	// shape and clock source decode straight from the register, so
	// they follow an accepted write in the very next cycle
	assign set_once_mode = cfg_q[`LPT_BIT_SETONCE];
	assign pwm_mode = ~cfg_q[`LPT_BIT_SETONCE];
	assign ext_clock_selected = cfg_q[`LPT_BIT_CLKSRC];

	// trigger source mux; reserved codes give no trigger
	// a quiet level there means an unused code can never start the timer
	always @* begin
		if (tsel <= `LPT_TSEL_LAST)
			trig_raw = trig_sources[tsel];
		else
			trig_raw = 1'b0;
	end

	// both filters run on core_clk, the internal clock
	// they only work while that clock runs; without it a level change
	// would sit in the filter and never pass
	lpt_glitch_filter u_trig_flt (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.filt_code(cfg_q[`LPT_TFLT_HI:`LPT_TFLT_LO]),
		.din(trig_raw),
		.dout_q(trg_f)
	);
	lpt_glitch_filter u_clk_flt (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.filt_code(cfg_q[`LPT_CFLT_HI:`LPT_CFLT_LO]),
		.din(ext_clock_in),
		.dout_q(ext_f)
	);

	// edge history of filtered signals; reset to the idle low level of
	// both inputs so no false edge is seen just after reset
	always @(posedge core_clk) begin
		if (!rst_n) begin
			trg_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			trg_q <= trg_f;
			ext_q <= ext_f;
		end
	end

	// valid trigger edge per enable field; 00 is software only
	// the edge is comb from the filter output and stands one cycle
	always @* begin
		if (ten == `LPT_TRG_SW)
			trig_valid = 1'b0;
		else if (ten == `LPT_TRG_RISE)
			trig_valid = edge_hit(`LPT_EDGE_RISE, trg_f, trg_q);
		else if (ten == `LPT_TRG_FALL)
			trig_valid = edge_hit(`LPT_EDGE_FALL, trg_f, trg_q);
		else
			trig_valid = edge_hit(`LPT_EDGE_BOTH, trg_f, trg_q);
	end

	// arm on start command when external trigger selected
	// a start command in the same cycle as a trigger edge wins, so the
	// arm is kept; disabling the timer always drops it
	always @(posedge core_clk) begin
		if (!rst_n || !timer_enable_bit)
			armed_q <= 1'b0;
		else if (ten != `LPT_TRG_SW && (continuous_start_cmd ||
			single_start_cmd))
			armed_q <= 1'b1;
		else if (armed_q && trig_valid)
			armed_q <= 1'b0;
	end

	// start and restart decisions
	// a stopped timer starts on a trigger edge only if armed; a running one restarts only
	// with the retrigger bit set, otherwise the edge is ignored
	always @* begin
		start_pulse = 1'b0;
		restart_pulse = 1'b0;
		if (timer_enable_bit) begin
			if (ten == `LPT_TRG_SW)
				start_pulse = continuous_start_cmd | single_start_cmd;
			else if (trig_valid && !timer_running)
				start_pulse = armed_q;
			else if (trig_valid && timer_running)
				restart_pulse = cfg_q[`LPT_BIT_RETRIG];
		end
	end

	// raw counting event: internal every cycle, else external edge
	// encoder mode counts every filtered change of the external input
	// both-edge mode assumes core_clk at least four times ext rate
	always @* begin
		if (!cfg_q[`LPT_BIT_CLKSRC])
			raw_tick = 1'b1;
		else if (cfg_q[`LPT_BIT_QUAD])
			raw_tick = ext_f ^ ext_q;
		else
			raw_tick = edge_hit(pol, ext_f, ext_q);
	end

	// encoder submode output when quadrature mode is enabled
	// polarity code 11 is not a sub-mode and shows as 00
	always @* begin
		if (cfg_q[`LPT_BIT_QUAD] && pol != 2'h3)
			quad_submode = pol;
		else
			quad_submode = 2'h0;
	end

	// prescaler: tick every 2^pre raw events
	// the terminal count is compared directly, so divide by 128 does not
	// depend on a sum that overflows the seven-bit counter
	always @* begin
		pre_hit = (pre_q == pre_top(pre));
	end

	// count raw events; count and tick clear while the timer is disabled
	always @(posedge core_clk) begin
		if (!rst_n || !timer_enable_bit) begin
			pre_q <= 7'h00;
			count_tick <= 1'b0;
		end else begin
			count_tick <= raw_tick & pre_hit;
			if (raw_tick)
				pre_q <= pre_hit ? 7'h00 : pre_q + 7'h01;
		end
	end
endmodule // lpt_config

// ### hdl/lpt_consts.vh
// constants for the low-power timer configuration block
`ifndef LPT_CONSTS_VH
`define LPT_CONSTS_VH
`define LPT_CFG_RESET 32'h0000_0000
`define LPT_CFG_WMASK 32'h03FF_EEDF
`define LPT_BIT_CLKSRC 0
`define LPT_POL_LO 1
`define LPT_POL_HI 2
`define LPT_CFLT_LO 3
`define LPT_CFLT_HI 4
`define LPT_TFLT_LO 6
`define LPT_TFLT_HI 7
`define LPT_PRE_LO 9
`define LPT_PRE_HI 11
`define LPT_TSEL_LO 13
`define LPT_TSEL_HI 16
`define LPT_TEN_LO 17
`define LPT_TEN_HI 18
`define LPT_BIT_RETRIG 19
`define LPT_BIT_SETONCE 20
`define LPT_BIT_QUAD 24
`define LPT_TSEL_LAST 4'h8
`define LPT_EDGE_RISE 2'h0
`define LPT_EDGE_FALL 2'h1
`define LPT_EDGE_BOTH 2'h2
`define LPT_TRG_SW 2'h0
`define LPT_TRG_RISE 2'h1
`define LPT_TRG_FALL 2'h2
`define LPT_FILT_MAX 4'h8
`endif

// ### hdl/lpt_glitch_filter.v
// digital glitch filter: level change accepted after n equal samples
`timescale 1ns/1ps
`include "lpt_consts.vh"
module lpt_glitch_filter (
	input wire core_clk,
	input wire rst_n,
	input wire [1:0] filt_code,
	input wire din,
	output reg dout_q
);
	reg [3:0] cnt_q;
	reg [3:0] need;
	// samples needed: code 00 immediate, else 2, 4, 8
	always @* begin
		case (filt_code)
		2'h1: need = 4'h2;
		2'h2: need = 4'h4;
		2'h3: need = `LPT_FILT_MAX;
		default: need = 4'h1;
		endcase
	end
	// count consecutive differing samples on the internal clock
	always @(posedge core_clk) begin
		if (!rst_n) begin
			dout_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (din == dout_q) begin
			cnt_q <= 4'h0;
		end else if (cnt_q + 4'h1 >= need) begin
			dout_q <= din;
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // lpt_glitch_filter

// ### bench/lpt_partner.sv
// trigger and external clock source model
`timescale 1ns/1ps
module lpt_partner (
	input wire core_clk,
	output logic [8:0] trig_sources,
	output logic ext_clock_in
);
	// all sources quiet, clock low outside bursts
	initial begin
		trig_sources = 9'h000;
		ext_clock_in = 1'b0;
	end
	// high pulse of n cycles on one source, then quiet
	task src(input int s, input int n);
		@(negedge core_clk) trig_sources[s] = 1'b1;
		repeat (n) @(negedge core_clk);
		trig_sources[s] = 1'b0;
		repeat (12) @(negedge core_clk);
	endtask
	// n periods of four core cycles each, so both edges stay visible
	task clk(input int n);
		repeat (2 * n) begin
			repeat (2) @(negedge core_clk);
			ext_clock_in = ~ext_clock_in;
		end
		repeat (12) @(negedge core_clk);
	endtask
endmodule // lpt_partner

// ### bench/lpt_config_properties.sv
// checker for the timer configuration block
`timescale 1ns/1ps
`include "lpt_consts.vh"
module lpt_config_properties (
	input wire core_clk,
	input wire rst_n,
	input wire cfg_wr,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire timer_enable_bit,
	input wire timer_running,
	input wire set_once_mode,
	input wire restart_pulse,
	input wire trig_valid,
	input wire [1:0] quad_submode,
	input wire ext_clock_selected
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// accepted single write
	sequence s_take;
		cfg_wr && !timer_enable_bit ##1 !cfg_wr;
	endsequence
	write_take_a: assert property (s_take |=>
		cfg_rdata == ($past(cfg_wdata, 2) & `LPT_CFG_WMASK)) else $error("wr");
	write_drop_a: assert property (
		timer_enable_bit && $past(timer_enable_bit) |=> $stable(cfg_rdata))
		else $error("drop");
	resv_zero_a: assert property (
		(cfg_rdata & ~`LPT_CFG_WMASK) == 32'h0) else $error("resv");
	shape_bit_a: assert property (
		cfg_rdata[20] == $past(set_once_mode)) else $error("shape");
	clk_src_a: assert property (
		cfg_rdata[0] == $past(ext_clock_selected)) else $error("count_clock_source");
	quad_sub_a: assert property ($past(quad_submode) ==
		((cfg_rdata[24] && cfg_rdata[2:1] != 2'h3) ?
		cfg_rdata[2:1] : 2'h0)) else $error("quad");
	retrig_only_a: assert property (
		restart_pulse |-> timer_running ##1 cfg_rdata[19]) else $error("rt");
	trig_gate_a: assert property (
		trig_valid |=> cfg_rdata[18:17] != 2'h0) else $error("trg");
endmodule // lpt_config_properties
bind lpt_config lpt_config_properties u_chk (.core_clk, .rst_n, .cfg_wr,
	.cfg_wdata, .cfg_rdata, .timer_enable_bit, .timer_running,
	.set_once_mode, .restart_pulse, .trig_valid, .quad_submode,
	.ext_clock_selected);

// ### bench/lpt_config_tb.sv
// self-checking bench for the timer configuration block
`timescale 1ns/1ps
`include "lpt_consts.vh"
module lpt_config_tb;
	logic core_clk, rst_n, cfg_wr, timer_enable_bit, continuous_start_cmd;
	logic single_start_cmd, timer_running, set_once_mode, pwm_mode;
	logic start_pulse, restart_pulse, armed_q, count_tick, trig_valid;
	logic ext_clock_selected, ext_clock_in;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [1:0] quad_submode;
	logic [8:0] trig_sources;
	int mismatches, n_checks;
	logic [31:0] nt, ns, nr, nk; // four-state, so an unknown event shows
	logic [35:0] rows [4] = '{36'hF_FFFF_FFFC, 36'h0_0100_0008,
		36'h0_0000_0014, 36'h0_1000_0042};
	logic [35:0] pr [3] = '{36'h0_0000_4012, 36'h0_0000_4054,
		36'h0_0000_0190};
	lpt_config DUT (.core_clk, .rst_n, .cfg_wr, .cfg_wdata, .cfg_rdata,
		.timer_enable_bit, .continuous_start_cmd, .single_start_cmd,
		.timer_running, .trig_sources, .ext_clock_in, .set_once_mode,
		.pwm_mode, .start_pulse, .restart_pulse, .armed_q, .count_tick,
		.quad_submode, .ext_clock_selected, .trig_valid);
	lpt_partner P (.core_clk, .trig_sources, .ext_clock_in);
	// clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// event counters
	always @(posedge core_clk) begin
		nt += trig_valid;
		ns += start_pulse;
		nr += restart_pulse;
		nk += count_tick;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [31:0] d);
		@(negedge core_clk) {cfg_wr, cfg_wdata} = {1'b1, d};
		@(negedge core_clk) cfg_wr = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask
	// configure while disabled, then enable and clear counters
	task cfg(input logic [31:0] d);
		timer_enable_bit = 1'b0;
		wr(d);
		timer_enable_bit = 1'b1;
		{nt, ns, nr, nk} = '0;
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
	initial begin
		{rst_n, cfg_wr, timer_enable_bit, continuous_start_cmd} = '0;
		{single_start_cmd, timer_running, cfg_wdata} = '0;
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		chk(cfg_rdata, 32'h0000_0000);
		foreach (rows[i]) begin
			wr(rows[i][35:4]);
			chk(cfg_rdata, rows[i][35:4] & `LPT_CFG_WMASK);
			chk({set_once_mode, ext_clock_selected, quad_submode},
				rows[i][3:0]);
			chk(pwm_mode, !rows[i][3]);
		end
		timer_enable_bit = 1'b1;
		wr(32'h0000_0000);
		chk(cfg_rdata, 32'h0100_0004);
		$display("register test done");
		for (int e = 0; e < 4; e++) begin
			cfg(32'h0000_C000 | e << 17);
			P.src(6, 1);
			P.src(5, 1);
			chk(nt, (e + 1) / 2);
		end
		cfg(32'h0002_C0C0);
		P.src(6, 7);
		chk(nt, 0);
		P.src(6, 8);
		chk(nt, 1);
		$display("trigger test done");
		timer_running = 1'b1;
		cfg(32'h000A_C000);
		P.src(6, 1);
		chk(nr, 1);
		cfg(32'h0002_C000);
		P.src(6, 1);
		chk(nr, 0);
		timer_running = 1'b0;
		cfg(32'h0002_C000);
		@(negedge core_clk) continuous_start_cmd = 1'b1;
		@(negedge core_clk) continuous_start_cmd = 1'b0;
		chk(armed_q, 1);
		P.src(6, 1);
		chk(ns, 1);
		cfg(32'h0000_C000);
		@(negedge core_clk) single_start_cmd = 1'b1;
		@(negedge core_clk) single_start_cmd = 1'b0;
		P.src(6, 1);
		chk(ns, 1);
		chk(nt, 0);
		chk(armed_q, 0);
		$display("start test done");
		foreach (pr[i]) begin
			cfg(pr[i][35:4]);
			P.clk(8);
			chk(nk, pr[i][3:0]);
		end
		cfg(32'h0000_0E00);
		repeat (300) @(negedge core_clk);
		chk(nk, 2);
		$display("prescale test done");
		@(negedge core_clk) rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		chk(cfg_rdata, 32'h0000_0000);
		chk(armed_q, 0);
		$display("reset test done");
		finish_test();
	end
endmodule // lpt_config_tb
